// ===== design/cipr_pkg.sv
// shared constants, types and register map of the core idle/perf state resolver
package cipr_pkg;

  // idle state codes, numerically ordered: deeper states have larger codes
  localparam int CS_W = 4;
  localparam logic [CS_W-1:0] CS_C0 = 4'h0;
  localparam logic [CS_W-1:0] CS_C1 = 4'h1;
  localparam logic [CS_W-1:0] CS_C3 = 4'h3;
  localparam logic [CS_W-1:0] CS_C6 = 4'h6;
  localparam logic [CS_W-1:0] CS_C10 = 4'ha;

  // legacy idle-level read window and its mapping onto idle states
  localparam logic [CS_W-1:0] LVL_MIN = 4'h2;
  localparam logic [CS_W-1:0] LVL_C3 = 4'h2;
  localparam logic [CS_W-1:0] LVL_C6 = 4'h3;
  localparam logic [CS_W-1:0] LVL_MAX = 4'h7;
  localparam logic [CS_W-1:0] LVL_DEEP_OFS = 4'h3;

  // performance point code width, larger code means higher frequency
  localparam int PS_W = 4;

  // demotion counter widths
  localparam int RES_W = 16;
  localparam int BURST_W = 8;

  // apb register map (byte addresses)
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] OFS_CFG = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_RES_THR = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_IRQ_THR = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_PSTATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_CSTATUS = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_TSTATUS = 8'h14;

  // idle_state_config_control fields
  localparam int CFG_DEM_C3_BIT = 0;
  localparam int CFG_DEM_C1_BIT = 1;
  localparam int CFG_REDIR_BIT = 2;
  localparam int CFG_W = 3;
  localparam logic [CFG_W-1:0] CFG_RST = 3'h0;
  localparam logic [RES_W-1:0] RES_THR_RST = 16'h0100;
  localparam logic [BURST_W-1:0] IRQ_C3_RST = 8'h04;
  localparam logic [BURST_W-1:0] IRQ_C1_EXTRA_RST = 8'h04;
  localparam int IRQ_C1_LSB = 8;

  // performance status fields
  localparam int PST_TGT_LSB = 4;
  localparam int PST_BUSY_BIT = 8;

  // source of a thread idle request
  typedef enum logic [1:0] {SRC_NONE, SRC_HALT, SRC_MONITOR_WAIT_INSTRUCTION, SRC_IOREAD} cipr_src_e;

  typedef struct packed {
    logic valid;
    cipr_src_e src;
    logic [CS_W-1:0] arg;
  } cipr_treq_s;

  typedef struct packed {
    logic irq;
    logic if_flag;
    logic mon_hit;
    logic deadline;
  } cipr_twake_s;

  typedef struct packed {
    logic flush_req;
    logic clk_stop;
    logic save_req;
    logic pwr_off;
    logic restore_req;
    logic snoop_en;
  } cipr_cctl_s;

endpackage

// ===== design/cipr_resolver.sv
// core idle and performance state resolver with apb configuration registers
//
// Operation
// - highest requested perf point across active cores
// - accept any time; defer until transition done
// - settle voltage first, then lock pll
// - idle states always pass through C0
// - power actions follow resolved core state only
// - core state is lowest thread request
// - any thread in C0 keeps core C0
// - wake on irq, monitor hit, deadline
// - thread-directed interrupt wakes that thread only
// - system reset re-initialises every core
// - in-range legacy read becomes wait request
// - out-of-range legacy read falls through
// - redirected requests: hint zero, break on irq
// - level 2 to C3, level 3 to C6
// - levels 4-7 map C7-C10, C6 behaviour
// - C1 only when all threads halted/waiting
// - snoops still serviced while in C1
// - C3: flush caches, keep state, stop clocks
// - snoops never wake a C3 core
// - C6: save state, power off; restore on exit
// - optional demotion to C3 and/or C1
// - C1 demotion needs higher interrupt rate
// - demotion off after reset, enabled by register
`timescale 1ns/1ps
module cipr_resolver #(
  parameter int NUM_CORES = 2,
  parameter int THREADS_PER_CORE = 2
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cipr_pkg::ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire cipr_pkg::cipr_treq_s [NUM_CORES*THREADS_PER_CORE-1:0] THREAD_REQ,
  input wire cipr_pkg::cipr_twake_s [NUM_CORES*THREADS_PER_CORE-1:0] THREAD_WAKE,
  output logic [NUM_CORES*THREADS_PER_CORE-1:0][cipr_pkg::CS_W-1:0] THREAD_CSTATE,
  output logic [NUM_CORES*THREADS_PER_CORE-1:0] IO_FALLTHRU,
  input wire logic [NUM_CORES-1:0] CORE_PREQ_VALID,
  input wire logic [NUM_CORES-1:0][cipr_pkg::PS_W-1:0] CORE_PREQ,
  input wire logic [NUM_CORES-1:0] CORE_FLUSH_DONE,
  input wire logic [NUM_CORES-1:0] CORE_SAVE_DONE,
  input wire logic [NUM_CORES-1:0] CORE_RESTORE_DONE,
  output cipr_pkg::cipr_cctl_s [NUM_CORES-1:0] CORE_CTRL,
  output logic [NUM_CORES-1:0][cipr_pkg::CS_W-1:0] CORE_CSTATE,
  output logic VOLT_REQ,
  output logic [cipr_pkg::PS_W-1:0] VOLT_TARGET,
  input wire logic VOLT_OK,
  output logic PLL_REQ,
  output logic [cipr_pkg::PS_W-1:0] FREQ_TARGET,
  input wire logic PLL_LOCKED,
  output logic PSTATE_BUSY
);
  import cipr_pkg::*;

  localparam int NT = NUM_CORES * THREADS_PER_CORE;

  // status registers pack four bits per core and per thread into one word
  if (NUM_CORES < 1 || THREADS_PER_CORE < 1 || NT * CS_W > 32) begin : g_bad_size
    $error("cipr_resolver: unsupported core or thread count");
  end

  typedef enum {CORE_RUN, CORE_HALT, CORE_FLUSH, CORE_CLKOFF, CORE_SAVE, CORE_PWROFF,
                CORE_RESTORE} cipr_core_e;
  typedef enum {PS_IDLE, PS_VOLT, PS_PLL} cipr_ps_e;

  // configuration registers
  logic [CFG_W-1:0] cfg_reg;
  logic [RES_W-1:0] res_thr_reg;
  logic [BURST_W-1:0] irq_c3_reg;
  logic [BURST_W-1:0] irq_c1x_reg;
  logic [31:0] prdata_reg;
  logic apb_wr;
  logic addr_hit;

  // per-thread and per-core observation
  logic [NT-1:0][CS_W-1:0] tstate_reg;
  logic [NUM_CORES-1:0][CS_W-1:0] core_eff;
  logic [NUM_CORES-1:0] core_active;
  logic [31:0] cstatus;
  logic [31:0] tstatus;

  // performance point state
  cipr_ps_e ps_state_reg;
  logic [NUM_CORES-1:0][PS_W-1:0] preq_reg;
  logic [PS_W-1:0] ps_cur_reg;
  logic [PS_W-1:0] ps_tgt_reg;
  logic [PS_W-1:0] ps_want;

  // register file on apb, zero wait states
  assign apb_wr = PSEL && PENABLE && PWRITE;
  assign addr_hit = (PADDR == OFS_CFG) || (PADDR == OFS_RES_THR) || (PADDR == OFS_IRQ_THR) ||
                    (PADDR == OFS_PSTATUS) || (PADDR == OFS_CSTATUS) ||
                    (PADDR == OFS_TSTATUS);
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL && PENABLE && !addr_hit;
  assign PRDATA = prdata_reg;

  // config writes; demotion stays off until software sets it
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      cfg_reg <= CFG_RST;
      res_thr_reg <= RES_THR_RST;
      irq_c3_reg <= IRQ_C3_RST;
      irq_c1x_reg <= IRQ_C1_EXTRA_RST;
    end else if (apb_wr) begin
      if (PADDR == OFS_CFG) begin
        cfg_reg <= PWDATA[CFG_W-1:0];
      end
      if (PADDR == OFS_RES_THR) begin
        res_thr_reg <= PWDATA[RES_W-1:0];
      end
      if (PADDR == OFS_IRQ_THR) begin
        irq_c3_reg <= PWDATA[BURST_W-1:0];
        irq_c1x_reg <= PWDATA[IRQ_C1_LSB +: BURST_W];
      end
    end
  end

  // read data captured in the setup phase so it comes from a flop in the access phase
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      prdata_reg <= 32'h0;
    end else if (PSEL && !PENABLE && !PWRITE) begin
      case (PADDR)
        OFS_CFG: prdata_reg <= {{(32-CFG_W){1'b0}}, cfg_reg};
        OFS_RES_THR: prdata_reg <= {{(32-RES_W){1'b0}}, res_thr_reg};
        OFS_IRQ_THR: prdata_reg <= {16'h0, irq_c1x_reg, irq_c3_reg};
        OFS_PSTATUS: prdata_reg <= {23'h0, PSTATE_BUSY, ps_want, ps_cur_reg};
        OFS_CSTATUS: prdata_reg <= cstatus;
        OFS_TSTATUS: prdata_reg <= tstatus;
        default: prdata_reg <= 32'h0;
      endcase
    end
  end

  // flatten per-core and per-thread states for status reads
  always_comb begin
    cstatus = 32'h0;
    tstatus = 32'h0;
    for (int c = 0; c < NUM_CORES; c++) begin
      cstatus[c*CS_W +: CS_W] = core_eff[c];
    end
    for (int t = 0; t < NT; t++) begin
      tstatus[t*CS_W +: CS_W] = tstate_reg[t];
    end
  end

  assign THREAD_CSTATE = tstate_reg;
  assign CORE_CSTATE = core_eff;

  // thread request decode and wake handling
  for (genvar t = 0; t < NT; t++) begin : g_thr
    logic brk_any_reg;
    logic mon_armed_reg;
    logic fall_reg;
    logic io_in_range;
    logic [CS_W-1:0] io_cs;
    logic [CS_W-1:0] req_cs;
    logic wake;

    // legacy level decode; redirection needs the config bit as well
    assign io_in_range = cfg_reg[CFG_REDIR_BIT] && THREAD_REQ[t].arg >= LVL_MIN &&
                         THREAD_REQ[t].arg <= LVL_MAX;
    always_comb begin
      if (THREAD_REQ[t].arg == LVL_C3) begin
        io_cs = CS_C3;
      end else if (THREAD_REQ[t].arg == LVL_C6) begin
        io_cs = CS_C6;
      end else begin
        io_cs = THREAD_REQ[t].arg + LVL_DEEP_OFS;
      end
    end

    // wait hints above the deepest code are clamped; hint zero means no request
    always_comb begin
      case (THREAD_REQ[t].src)
        SRC_HALT: req_cs = CS_C1;
        SRC_MONITOR_WAIT_INSTRUCTION: req_cs = (THREAD_REQ[t].arg > CS_C10) ? CS_C10 : THREAD_REQ[t].arg;
        SRC_IOREAD: req_cs = io_in_range ? io_cs : CS_C0;
        default: req_cs = CS_C0;
      endcase
    end

    // wake only this thread on its own events; masked irq wakes redirected waits
    assign wake = tstate_reg[t] != CS_C0 &&
                  ((THREAD_WAKE[t].irq && (THREAD_WAKE[t].if_flag || brk_any_reg)) ||
                   (mon_armed_reg && (THREAD_WAKE[t].mon_hit || THREAD_WAKE[t].deadline)));

    // new idle request only from C0, every exit goes back to C0
    always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
        tstate_reg[t] <= CS_C0;
        brk_any_reg <= 1'b0;
        mon_armed_reg <= 1'b0;
      end else if (wake) begin
        tstate_reg[t] <= CS_C0;
        brk_any_reg <= 1'b0;
        mon_armed_reg <= 1'b0;
      end else if (tstate_reg[t] == CS_C0 && THREAD_REQ[t].valid && req_cs != CS_C0) begin
        tstate_reg[t] <= req_cs;
        brk_any_reg <= THREAD_REQ[t].src == SRC_IOREAD;
        mon_armed_reg <= THREAD_REQ[t].src == SRC_MONITOR_WAIT_INSTRUCTION;
      end
    end

    // out-of-range legacy reads are passed on as ordinary port reads
    always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
        fall_reg <= 1'b0;
      end else begin
        fall_reg <= THREAD_REQ[t].valid && THREAD_REQ[t].src == SRC_IOREAD &&
                    !io_in_range && tstate_reg[t] == CS_C0;
      end
    end
    assign IO_FALLTHRU[t] = fall_reg;
  end

  // per-core resolution, demotion and power sequencing
  for (genvar c = 0; c < NUM_CORES; c++) begin : g_core
    cipr_core_e st_reg;
    logic [CS_W-1:0] resolved;
    logic [CS_W-1:0] target;
    logic core_irq;
    logic deep;
    logic [RES_W-1:0] res_cnt_reg;
    logic [BURST_W-1:0] burst_reg;
    logic [BURST_W:0] c1_thr;

    // lowest thread state wins; any thread in C0 forces C0, C1 needs all threads idle
    always_comb begin
      resolved = tstate_reg[c*THREADS_PER_CORE];
      core_irq = 1'b0;
      for (int t = 0; t < THREADS_PER_CORE; t++) begin
        if (tstate_reg[c*THREADS_PER_CORE+t] < resolved) begin
          resolved = tstate_reg[c*THREADS_PER_CORE+t];
        end
        core_irq = core_irq | THREAD_WAKE[c*THREADS_PER_CORE+t].irq;
      end
    end

    // residency clock runs only in clock-stopped or powered-off states
    assign deep = st_reg == CORE_CLKOFF || st_reg == CORE_PWROFF;

    // short stays between interrupts build the burst count, a long stay clears it
    always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
        res_cnt_reg <= '0;
        burst_reg <= '0;
      end else if (core_irq) begin
        res_cnt_reg <= '0;
        if (res_cnt_reg >= res_thr_reg) begin
          burst_reg <= '0;
        end else if (burst_reg != {BURST_W{1'b1}}) begin
          burst_reg <= burst_reg + 1'b1;
        end
      end else if (deep && res_cnt_reg != {RES_W{1'b1}}) begin
        res_cnt_reg <= res_cnt_reg + 1'b1;
      end
    end

    // the C1 bar sits strictly above the C3 bar, extra of zero still adds one
    assign c1_thr = {1'b0, irq_c3_reg} + {1'b0, irq_c1x_reg} +
                    {{BURST_W{1'b0}}, irq_c1x_reg == '0};

    // demotion applies to deep requests only and only when enabled
    always_comb begin
      target = resolved;
      if (cfg_reg[CFG_DEM_C1_BIT] && resolved >= CS_C3 &&
          {1'b0, burst_reg} >= c1_thr) begin
        target = CS_C1;
      end else if (cfg_reg[CFG_DEM_C3_BIT] && resolved >= CS_C6 &&
                   burst_reg >= irq_c3_reg) begin
        target = CS_C3;
      end
    end

    // entry only from run, exit only once the resolved state is back at C0
    always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
        st_reg <= CORE_RUN;
      end else begin
        case (st_reg)
          CORE_RUN: begin
            if (target == CS_C1) begin
              st_reg <= CORE_HALT;
            end else if (target != CS_C0) begin
              st_reg <= CORE_FLUSH;
            end
          end
          CORE_HALT: begin
            if (resolved == CS_C0) begin
              st_reg <= CORE_RUN;
            end
          end
          CORE_FLUSH: begin
            if (CORE_FLUSH_DONE[c]) begin
              st_reg <= (target >= CS_C6) ? CORE_SAVE : CORE_CLKOFF;
            end
          end
          CORE_CLKOFF: begin
            if (resolved == CS_C0) begin
              st_reg <= CORE_RUN;
            end
          end
          CORE_SAVE: begin
            if (CORE_SAVE_DONE[c]) begin
              st_reg <= CORE_PWROFF;
            end
          end
          CORE_PWROFF: begin
            if (resolved == CS_C0) begin
              st_reg <= CORE_RESTORE;
            end
          end
          CORE_RESTORE: begin
            if (CORE_RESTORE_DONE[c]) begin
              st_reg <= CORE_RUN;
            end
          end
          default: st_reg <= CORE_RUN;
        endcase
      end
    end

    // sequencer outputs; snoops are served while running or halted, never in deep states
    always_comb begin
      CORE_CTRL[c].flush_req = st_reg == CORE_FLUSH;
      CORE_CTRL[c].clk_stop = st_reg == CORE_CLKOFF || st_reg == CORE_SAVE ||
                              st_reg == CORE_PWROFF;
      CORE_CTRL[c].save_req = st_reg == CORE_SAVE;
      CORE_CTRL[c].pwr_off = st_reg == CORE_PWROFF;
      CORE_CTRL[c].restore_req = st_reg == CORE_RESTORE;
      CORE_CTRL[c].snoop_en = st_reg == CORE_RUN || st_reg == CORE_HALT;
      case (st_reg)
        CORE_HALT: core_eff[c] = CS_C1;
        CORE_CLKOFF: core_eff[c] = CS_C3;
        CORE_PWROFF: core_eff[c] = CS_C6;
        default: core_eff[c] = CS_C0;
      endcase
    end
    assign core_active[c] = st_reg == CORE_RUN;

    // latest perf request per core, accepted at any time
    always_ff @(posedge REF_CLK) begin
      if (!RST_B) begin
        preq_reg[c] <= '0;
      end else if (CORE_PREQ_VALID[c]) begin
        preq_reg[c] <= CORE_PREQ[c];
      end
    end
  end

  // highest request among running cores; with none running the point is held
  always_comb begin
    ps_want = ps_cur_reg;
    if (|core_active) begin
      ps_want = '0;
      for (int c = 0; c < NUM_CORES; c++) begin
        if (core_active[c] && preq_reg[c] > ps_want) begin
          ps_want = preq_reg[c];
        end
      end
    end
  end

  // one transition at a time: a newer wish waits for the running one to finish
  always_ff @(posedge REF_CLK) begin
    if (!RST_B) begin
      ps_state_reg <= PS_IDLE;
      ps_cur_reg <= '0;
      ps_tgt_reg <= '0;
    end else begin
      case (ps_state_reg)
        PS_IDLE: begin
          if (ps_want != ps_cur_reg) begin
            ps_tgt_reg <= ps_want;
            ps_state_reg <= PS_VOLT;
          end
        end
        PS_VOLT: begin
          if (VOLT_OK) begin
            ps_state_reg <= PS_PLL;
          end
        end
        PS_PLL: begin
          if (PLL_LOCKED) begin
            ps_cur_reg <= ps_tgt_reg;
            ps_state_reg <= PS_IDLE;
          end
        end
        default: ps_state_reg <= PS_IDLE;
      endcase
    end
  end

  // voltage request precedes the pll lock request, never overlapping
  assign VOLT_REQ = ps_state_reg == PS_VOLT;
  assign PLL_REQ = ps_state_reg == PS_PLL;
  assign VOLT_TARGET = ps_tgt_reg;
  assign FREQ_TARGET = ps_tgt_reg;
  assign PSTATE_BUSY = ps_state_reg != PS_IDLE;

endmodule

// ===== test/cipr_core_model.sv
// core-side partner: answers flush, save, restore, voltage and lock requests
`timescale 1ns/1ps
module cipr_core_model (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] dly,
  input wire cipr_pkg::cipr_cctl_s [1:0] core_ctrl,
  input wire logic volt_req,
  input wire logic pll_req,
  output logic [1:0] flush_done,
  output logic [1:0] save_done,
  output logic [1:0] restore_done,
  output logic volt_ok,
  output logic pll_locked
);
  import cipr_pkg::*;
  logic [7:0] req;
  logic [7:0] ack;
  logic [3:0] cnt [8];
  // request bits in the same order as the answer bits
  assign req = {pll_req, volt_req, core_ctrl[1].restore_req, core_ctrl[0].restore_req,
    core_ctrl[1].save_req, core_ctrl[0].save_req, core_ctrl[1].flush_req, core_ctrl[0].flush_req};
  // age of each standing request; a dropped request restarts its count
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (!rst_b || !req[i]) begin
        cnt[i] <= 4'h0;
      end else if (cnt[i] != 4'hf) begin
        cnt[i] <= cnt[i] + 4'h1;
      end
    end
  end
  // answer only while the request stands, so no stale acknowledge lingers
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      ack[i] = req[i] && cnt[i] >= dly;
    end
  end
  assign {pll_locked, volt_ok, restore_done, save_done, flush_done} = ack;
endmodule

// ===== test/cipr_resolver_monitor.sv
// port-level assertions for the idle and perf state resolver
`timescale 1ns/1ps
module cipr_resolver_monitor #(
  parameter int NUM_CORES = 2,
  parameter int THREADS_PER_CORE = 2
) (
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire cipr_pkg::cipr_treq_s [NUM_CORES*THREADS_PER_CORE-1:0] THREAD_REQ,
  input wire cipr_pkg::cipr_twake_s [NUM_CORES*THREADS_PER_CORE-1:0] THREAD_WAKE,
  input wire logic [NUM_CORES*THREADS_PER_CORE-1:0][cipr_pkg::CS_W-1:0] THREAD_CSTATE,
  input wire logic [NUM_CORES*THREADS_PER_CORE-1:0] IO_FALLTHRU,
  input wire logic [NUM_CORES-1:0] CORE_FLUSH_DONE,
  input wire logic [NUM_CORES-1:0] CORE_SAVE_DONE,
  input wire cipr_pkg::cipr_cctl_s [NUM_CORES-1:0] CORE_CTRL,
  input wire logic [NUM_CORES-1:0][cipr_pkg::CS_W-1:0] CORE_CSTATE,
  input wire logic VOLT_REQ,
  input wire logic [cipr_pkg::PS_W-1:0] VOLT_TARGET,
  input wire logic VOLT_OK,
  input wire logic PLL_REQ,
  input wire logic [cipr_pkg::PS_W-1:0] FREQ_TARGET
);
  import cipr_pkg::*;
  // one clock domain, so clock and disable are declared once
  default clocking cb @(posedge REF_CLK);
  endclocking
  default disable iff (!RST_B);
  // acknowledge steps of the perf and deep idle sequences
  sequence s_volt_ack;
    VOLT_REQ && VOLT_OK;
  endsequence
  sequence s_save_ack;
    CORE_CTRL[0].save_req && CORE_SAVE_DONE[0];
  endsequence
  chk_volt_then_pll: assert property (s_volt_ack |=> PLL_REQ && !VOLT_REQ)
    else $error("pll step missing after voltage");
  chk_one_target: assert property (PLL_REQ |-> FREQ_TARGET == VOLT_TARGET)
    else $error("targets differ");
  chk_save_then_off: assert property (s_save_ack |=> CORE_CTRL[0].pwr_off)
    else $error("no power off after save");
  chk_flush_first: assert property ($rose(CORE_CTRL[0].clk_stop) |->
    $past(CORE_CTRL[0].flush_req && CORE_FLUSH_DONE[0]))
    else $error("clock stop without flush");
  chk_thread_via_c0: assert property ($changed(THREAD_CSTATE[0]) |->
    THREAD_CSTATE[0] == CS_C0 || $past(THREAD_CSTATE[0]) == CS_C0)
    else $error("idle to idle move");
  chk_halt_all: assert property ($rose(CORE_CSTATE[0] == CS_C1) |->
    $past(THREAD_CSTATE[0] != CS_C0 && THREAD_CSTATE[1] != CS_C0))
    else $error("halt with a running thread");
  chk_core_wakes: assert property ((CORE_CSTATE[0] == CS_C1 || CORE_CSTATE[0] == CS_C3) &&
    (THREAD_CSTATE[0] == CS_C0 || THREAD_CSTATE[1] == CS_C0) |=> CORE_CSTATE[0] == CS_C0)
    else $error("core stayed idle");
  chk_fallthru_cause: assert property (IO_FALLTHRU[0] |-> $past(THREAD_REQ[0].valid &&
    THREAD_REQ[0].src == SRC_IOREAD && THREAD_CSTATE[0] == CS_C0))
    else $error("fall-through without read");
  chk_irq_wake: assert property (THREAD_CSTATE[0] != CS_C0 && THREAD_WAKE[0].irq &&
    THREAD_WAKE[0].if_flag |=> THREAD_CSTATE[0] == CS_C0)
    else $error("interrupt did not wake");
  chk_snoop_c1: assert property (CORE_CSTATE[0] == CS_C1 |-> CORE_CTRL[0].snoop_en)
    else $error("snoops off in halt");
endmodule

// ===== test/tb_cipr_resolver.sv
// self-checking bench for the idle and perf state resolver
`timescale 1ns/1ps
module tb_cipr_resolver;
  import cipr_pkg::*;
  typedef struct packed {
    cipr_src_e src;
    logic [3:0] arg;
    logic [2:0] cfg;
    logic [3:0] st;
    logic ft;
  } cipr_row_s;
  // request and config, then thread state and fall-through expected
  localparam cipr_row_s ROWS [13] = '{
    '{SRC_HALT, 4'h0, 3'h0, 4'h1, 1'b0},
    '{SRC_MONITOR_WAIT_INSTRUCTION, 4'h3, 3'h0, 4'h3, 1'b0},
    '{SRC_MONITOR_WAIT_INSTRUCTION, 4'hc, 3'h0, 4'ha, 1'b0},
    '{SRC_MONITOR_WAIT_INSTRUCTION, 4'h0, 3'h0, 4'h0, 1'b0},
    '{SRC_IOREAD, 4'h2, 3'h4, 4'h3, 1'b0},
    '{SRC_IOREAD, 4'h3, 3'h4, 4'h6, 1'b0},
    '{SRC_IOREAD, 4'h4, 3'h4, 4'h7, 1'b0},
    '{SRC_IOREAD, 4'h5, 3'h4, 4'h8, 1'b0},
    '{SRC_IOREAD, 4'h6, 3'h4, 4'h9, 1'b0},
    '{SRC_IOREAD, 4'h7, 3'h4, 4'ha, 1'b0},
    '{SRC_IOREAD, 4'h1, 3'h4, 4'h0, 1'b1},
    '{SRC_IOREAD, 4'h8, 3'h4, 4'h0, 1'b1},
    '{SRC_IOREAD, 4'h2, 3'h0, 4'h0, 1'b1}
  };
  logic REF_CLK = 1'b0;
  logic RST_B = 1'b0;
  logic PSEL = 1'b0;
  logic PENABLE = 1'b0;
  logic PWRITE = 1'b0;
  logic [ADDR_W-1:0] PADDR = 8'h00;
  logic [31:0] PWDATA = 32'h0;
  logic [31:0] PRDATA;
  logic PREADY, PSLVERR, VOLT_REQ, VOLT_OK, PLL_REQ, PLL_LOCKED, PSTATE_BUSY;
  cipr_treq_s [3:0] THREAD_REQ = '0;
  cipr_twake_s [3:0] THREAD_WAKE = '0;
  logic [3:0][CS_W-1:0] THREAD_CSTATE;
  logic [3:0] IO_FALLTHRU;
  logic [1:0] CORE_PREQ_VALID = 2'h0;
  logic [1:0][PS_W-1:0] CORE_PREQ = '0;
  logic [1:0] CORE_FLUSH_DONE, CORE_SAVE_DONE, CORE_RESTORE_DONE;
  cipr_cctl_s [1:0] CORE_CTRL;
  logic [1:0][CS_W-1:0] CORE_CSTATE;
  logic [PS_W-1:0] VOLT_TARGET, FREQ_TARGET;
  logic [3:0] dly = 4'h0;
  logic [31:0] rd;
  logic err;
  int fail_count = 0;
  int check_count = 0;
  int cyc = 0;
  int i;
  cipr_resolver uut (.*);
  cipr_core_model model (
    .clk(REF_CLK),
    .rst_b(RST_B),
    .dly(dly),
    .core_ctrl(CORE_CTRL),
    .volt_req(VOLT_REQ),
    .pll_req(PLL_REQ),
    .flush_done(CORE_FLUSH_DONE),
    .save_done(CORE_SAVE_DONE),
    .restore_done(CORE_RESTORE_DONE),
    .volt_ok(VOLT_OK),
    .pll_locked(PLL_LOCKED)
  );
  initial begin
    forever #25 REF_CLK = ~REF_CLK;
  end
  // hang guard: far above the few hundred cycles the tests need
  always @(posedge REF_CLK) begin
    cyc++;
    if (cyc == 8000) begin
      fail_count++;
      conclude();
    end
  end
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d);
    @(posedge REF_CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'b1;
    @(posedge REF_CLK);
    while (PREADY !== 1'b1) @(posedge REF_CLK);
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  task automatic treq(input int t, input cipr_src_e s, input logic [3:0] a);
    @(posedge REF_CLK);
    THREAD_REQ[t] <= '{1'b1, s, a};
    @(posedge REF_CLK);
    THREAD_REQ[t] <= '0;
  endtask
  task automatic wake(input int t, input logic [3:0] w);
    @(posedge REF_CLK);
    THREAD_WAKE[t] <= w;
    @(posedge REF_CLK);
    THREAD_WAKE[t] <= '0;
  endtask
  task automatic wait_core(input int c, input logic [3:0] e);
    int k;
    for (k = 0; k < 40 && CORE_CSTATE[c] !== e; k++) @(negedge REF_CLK);
    chk("core_state", e, CORE_CSTATE[c]);
  endtask
  task automatic do_reset();
    @(posedge REF_CLK);
    RST_B <= 1'b0;
    repeat (20) @(posedge REF_CLK);
    RST_B <= 1'b1;
    @(posedge REF_CLK);
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    do_reset();
    apb(1'b0, OFS_CFG, 32'h0);
    chk("cfg", {29'h0, CFG_RST}, rd);
    apb(1'b0, OFS_RES_THR, 32'h0);
    chk("res_thr", {16'h0, RES_THR_RST}, rd);
    apb(1'b0, OFS_IRQ_THR, 32'h0);
    chk("irq_thr", {16'h0, IRQ_C1_EXTRA_RST, IRQ_C3_RST}, rd);
    apb(1'b1, OFS_PSTATUS, 32'hff);
    apb(1'b0, OFS_PSTATUS, 32'h0);
    chk("pstatus_ro", 32'h0, rd);
    apb(1'b0, 8'h40, 32'h0);
    chk("unmapped", 1'b1, err);
    $display("test registers done");
    // legacy reads wake on a masked interrupt, others need the flag
    foreach (ROWS[j]) begin
      apb(1'b1, OFS_CFG, {29'h0, ROWS[j].cfg});
      treq(0, ROWS[j].src, ROWS[j].arg);
      @(negedge REF_CLK);
      chk("thread_state", ROWS[j].st, THREAD_CSTATE[0]);
      chk("fallthru", ROWS[j].ft, IO_FALLTHRU[0]);
      wake(0, {1'b1, ROWS[j].src != SRC_IOREAD, 2'b00});
      @(negedge REF_CLK);
      chk("woken", CS_C0, THREAD_CSTATE[0]);
    end
    $display("test rows done");
    dly <= 4'h2;
    treq(0, SRC_HALT, 4'h0);
    @(negedge REF_CLK);
    chk("one_halted", CS_C0, CORE_CSTATE[0]);
    treq(1, SRC_HALT, 4'h0);
    wait_core(0, CS_C1);
    chk("snoop", 1'b1, CORE_CTRL[0].snoop_en);
    wake(1, 4'b1100);
    @(negedge REF_CLK);
    chk("other_thread", CS_C1, THREAD_CSTATE[0]);
    wait_core(0, CS_C0);
    wake(0, 4'b1100);
    treq(0, SRC_MONITOR_WAIT_INSTRUCTION, CS_C6);
    treq(1, SRC_MONITOR_WAIT_INSTRUCTION, CS_C3);
    wait_core(0, CS_C3);
    chk("clk_stop", 1'b1, CORE_CTRL[0].clk_stop);
    wake(1, 4'b0010);
    wait_core(0, CS_C0);
    chk("deep_thread", CS_C6, THREAD_CSTATE[0]);
    treq(1, SRC_MONITOR_WAIT_INSTRUCTION, CS_C6);
    wait_core(0, CS_C6);
    chk("pwr_off", 1'b1, CORE_CTRL[0].pwr_off);
    apb(1'b0, OFS_CSTATUS, 32'h0);
    chk("cstatus", {28'h0, CS_C6}, rd);
    apb(1'b0, OFS_TSTATUS, 32'h0);
    chk("tstatus", {24'h0, CS_C6, CS_C6}, rd);
    // leaving power-off must restore first, then a new request re-enters
    wake(0, 4'b1100);
    for (i = 0; i < 40 && CORE_CTRL[0].restore_req !== 1'b1; i++) @(negedge REF_CLK);
    chk("restore", 6'h02, CORE_CTRL[0]);
    treq(0, SRC_MONITOR_WAIT_INSTRUCTION, CS_C6);
    wait_core(0, CS_C6);
    $display("test core states done");
    // reset while powered off also clears the interrupt burst count
    do_reset();
    @(negedge REF_CLK);
    chk("core_reset", CS_C0, CORE_CSTATE[0]);
    chk("thread_reset", CS_C0, THREAD_CSTATE[0]);
    chk("ctrl_reset", 6'h01, CORE_CTRL[0]);
    repeat (5) wake(0, 4'b1000);
    apb(1'b1, OFS_CFG, 32'h3);
    treq(0, SRC_MONITOR_WAIT_INSTRUCTION, CS_C6);
    treq(1, SRC_MONITOR_WAIT_INSTRUCTION, CS_C6);
    wait_core(0, CS_C3);
    wake(0, 4'b1100);
    wake(1, 4'b1100);
    repeat (3) wake(0, 4'b1000);
    treq(0, SRC_MONITOR_WAIT_INSTRUCTION, CS_C6);
    treq(1, SRC_MONITOR_WAIT_INSTRUCTION, CS_C6);
    wait_core(0, CS_C1);
    wake(0, 4'b1100);
    wake(1, 4'b1100);
    $display("test demotion done");
    // slow partner so the second request lands mid-transition
    dly <= 4'h3;
    @(posedge REF_CLK);
    CORE_PREQ_VALID <= 2'h3;
    CORE_PREQ <= {4'h9, 4'h5};
    @(posedge REF_CLK);
    CORE_PREQ_VALID <= 2'h0;
    for (i = 0; i < 40 && PLL_REQ !== 1'b1; i++) @(negedge REF_CLK);
    chk("freq", 4'h9, FREQ_TARGET);
    @(posedge REF_CLK);
    CORE_PREQ_VALID <= 2'h2;
    CORE_PREQ[1] <= 4'h3;
    @(posedge REF_CLK);
    CORE_PREQ_VALID <= 2'h0;
    for (i = 0; i < 40 && PSTATE_BUSY !== 1'b0; i++) @(negedge REF_CLK);
    for (i = 0; i < 40 && PLL_REQ !== 1'b1; i++) @(negedge REF_CLK);
    chk("freq_next", 4'h5, FREQ_TARGET);
    for (i = 0; i < 40 && PSTATE_BUSY !== 1'b0; i++) @(negedge REF_CLK);
    apb(1'b0, OFS_PSTATUS, 32'h0);
    chk("pstatus", 32'h55, rd);
    $display("test perf done");
    conclude();
  end
endmodule
bind cipr_resolver cipr_resolver_monitor #(
  .NUM_CORES(NUM_CORES),
  .THREADS_PER_CORE(THREADS_PER_CORE)
) mon (.*);
